/* rpc_defs.vh */
// Register offsets, field positions, reset values and modes for the radio packet config block
`ifndef RPC_DEFS_VH
`define RPC_DEFS_VH

// ----------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define RPC_IDX_SYNC_HIGH 16'hdf00
`define RPC_IDX_SYNC_LOW 16'hdf01
`define RPC_IDX_PKT_LEN 16'hdf02
`define RPC_IDX_PKT_CTRL1 16'hdf03
`define RPC_IDX_PKT_CTRL0 16'hdf04
`define RPC_IDX_DEV_ADDR 16'hdf05
`define RPC_IDX_PIN_TWO 16'hdf2f
`define RPC_IDX_PIN_ONE 16'hdf30
`define RPC_IDX_PIN_ZERO 16'hdf31
`define RPC_IDX_PQ_STATUS 16'hdf3c

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RPC_RST_SYNC_HIGH 8'hd3
`define RPC_RST_SYNC_LOW 8'h91
`define RPC_RST_PKT_LEN 8'hff
`define RPC_RST_PKT_CTRL1 8'h04
`define RPC_RST_PKT_CTRL0 8'h01
`define RPC_RST_DEV_ADDR 8'h00
`define RPC_RST_PIN_CFG 8'h00

// ----------------------------------------------------------------
// Writable bit masks and field positions
// ----------------------------------------------------------------
`define RPC_MASK_PIN_TWO 8'h7f
`define RPC_MASK_PIN_ONE 8'hff
`define RPC_MASK_PIN_ZERO 8'h7f
`define RPC_MASK_PKT_CTRL1 8'he7
`define RPC_MASK_PKT_CTRL0 8'h03
`define RPC_BIT_INVERT 6
`define RPC_BIT_DRIVE 7
`define RPC_SEL_HI 5
`define RPC_PQT_HI 7
`define RPC_PQT_LO 5
`define RPC_BIT_APPEND 2
`define RPC_ADR_HI 1
`define RPC_LEN_HI 1

// ----------------------------------------------------------------
// Modes and estimator constants
// ----------------------------------------------------------------
`define RPC_ADR_NONE 2'h0
`define RPC_ADR_NOBC 2'h1
`define RPC_ADR_BC0 2'h2
`define RPC_ADR_BC0FF 2'h3
`define RPC_LEN_FIXED 2'h0
`define RPC_LEN_VAR 2'h1
`define RPC_PQ_STEP_UP 8'h01
`define RPC_PQ_STEP_DOWN 8'h08
`define RPC_BCAST_ZERO 8'h00
`define RPC_BCAST_ALL 8'hff

`endif

/* rpc_pq_estimator.v */
// Preamble quality counter that gates sync word detection
`timescale 1ns/10ps
`include "rpc_defs.vh"

module rpc_pq_estimator #(
    parameter CNT_W = 8
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Received bit stream
    input wire bit_valid_i,
    input wire bit_i,
    input wire restart_i,
    // Threshold and result
    input wire [2:0] threshold_i,
    output reg [CNT_W-1:0] count_o,
    output wire reached_o
);

reg last_bit;
reg have_last;

// ----------------------------------------------------------------
// Counter update
// ----------------------------------------------------------------
// Saturates at both ends so a long run cannot wrap to a high count
always @(posedge clk_i)
begin
    if (!rst_n_i || restart_i)
    begin
        count_o <= {CNT_W{1'b0}};
        last_bit <= 1'b0;
        have_last <= 1'b0;
    end
    else if (bit_valid_i)
    begin
        last_bit <= bit_i;
        have_last <= 1'b1;
        if (have_last)
        begin
            if (bit_i != last_bit)
            begin
                if (count_o != {CNT_W{1'b1}})
                    count_o <= count_o + `RPC_PQ_STEP_UP;
            end
            else if (count_o >= `RPC_PQ_STEP_DOWN)
                count_o <= count_o - `RPC_PQ_STEP_DOWN;
            else
                count_o <= {CNT_W{1'b0}};
        end
    end
end

assign reached_o = (count_o >= {{(CNT_W-5){1'b0}}, threshold_i, 2'b00});

endmodule // rpc_pq_estimator

/* rpc_config_regs.v */
// Radio packet handler configuration registers with debug pin muxing
`timescale 1ns/10ps
`include "rpc_defs.vh"

// What this block does
// - Bit 6 of each pin register inverts that debug pin's output.
// - Bits 5:0 select the internal signal per debug pin; reset zero.
// - Pin one register bit 7 selects minimum or maximum debug drive.
// - Sync word high byte resets 0xd3, low byte resets 0x91.
// - Length register is fixed length or variable maximum; resets 0xff.
// - Quality counter rises one on bit change, falls eight on repeat.
// - Sync accepted when counter reaches four times threshold; zero always.
// - Status_bytes_enable bit, reset one, adds two status bytes after payload.
// - Address filter mode: none, exact, add 0x00, add 0x00 and 0xff.
// - Received address compares against device address register, reset zero.
// - Variable mode takes length from first byte after sync word.
module rpc_config_regs #(
    parameter SIG_COUNT = 64,
    parameter PQ_W = 8
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Avalon-MM slave
    input wire [17:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output reg [31:0] avs_readdata_o,
    output wire avs_waitrequest_o,
    output reg [1:0] avs_response_o,
    // Internal radio signals for debug muxing
    input wire [SIG_COUNT-1:0] radio_signals_i,
    // Debug pins
    output reg debug_pin_two_o,
    output reg debug_pin_one_o,
    output reg debug_pin_zero_o,
    output wire debug_drive_strength_o,
    // Receive bit stream from demodulator
    input wire rx_bit_valid_i,
    input wire rx_bit_i,
    input wire rx_search_start_i,
    input wire sync_match_i,
    // Receive byte stream after sync
    input wire rx_byte_valid_i,
    input wire [7:0] rx_byte_i,
    // Packet handler results
    output reg sync_detected_o,
    output reg [7:0] packet_length_o,
    output reg length_valid_o,
    output reg address_ok_o,
    output reg address_valid_o,
    output wire status_bytes_enable_o,
    output wire [15:0] sync_word_o
);

// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
reg [7:0] sync_word_high;
reg [7:0] sync_word_low;
reg [7:0] packet_length_limit;
reg [7:0] packet_control_first;
reg [7:0] packet_control_zero;
reg [7:0] device_address;
reg [7:0] debug_pin_two_config;
reg [7:0] debug_pin_one_config;
reg [7:0] debug_pin_zero_config;
reg ack;
reg [1:0] byte_index;
reg in_packet;
wire [PQ_W-1:0] pq_count;
wire pq_reached;
wire access;
wire [15:0] index;
wire aligned_ok;
wire [7:0] wdata;
wire wr_en;
reg hit;
reg [7:0] next_rdata;
reg next_address_ok;
reg [7:0] next_packet_length;
wire addr_match;
wire bcast_zero;
wire bcast_all;
// Three debug pins, one config byte each
localparam PIN_COUNT = 3;
wire [8*PIN_COUNT-1:0] pin_cfg_all;

// ----------------------------------------------------------------
// Bus decode
// ----------------------------------------------------------------
// One wait cycle per access keeps read data registered
assign access = (avs_read_i || avs_write_i) && !ack;
assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack;
assign index = avs_address_i[17:2];
assign aligned_ok = (avs_address_i[1:0] == 2'b00);
assign wdata = avs_writedata_i[7:0];
// Writes land only at the edge that ends the wait state,
// when the master is known to hold the same request
assign wr_en = ack && avs_write_i && aligned_ok && avs_byteenable_i[0];

// Address hit and read mux
always @*
begin
    hit = 1'b1;
    next_rdata = 8'h00;
    case (index)
        `RPC_IDX_SYNC_HIGH: next_rdata = sync_word_high;
        `RPC_IDX_SYNC_LOW: next_rdata = sync_word_low;
        `RPC_IDX_PKT_LEN: next_rdata = packet_length_limit;
        `RPC_IDX_PKT_CTRL1: next_rdata = packet_control_first;
        `RPC_IDX_PKT_CTRL0: next_rdata = packet_control_zero;
        `RPC_IDX_DEV_ADDR: next_rdata = device_address;
        `RPC_IDX_PIN_TWO: next_rdata = debug_pin_two_config;
        `RPC_IDX_PIN_ONE: next_rdata = debug_pin_one_config;
        `RPC_IDX_PIN_ZERO: next_rdata = debug_pin_zero_config;
        `RPC_IDX_PQ_STATUS: next_rdata = pq_count[7:0];
        default: hit = 1'b0;
    endcase
    if (!aligned_ok)
        hit = 1'b0;
end

// Answer, read data and slave error for unmapped words
always @(posedge clk_i)
begin
    if (!rst_n_i)
    begin
        ack <= 1'b0;
        avs_readdata_o <= 32'h0000_0000;
        avs_response_o <= 2'h0;
    end
    else
    begin
        ack <= access;
        if (access)
        begin
            avs_readdata_o <= {24'h00_0000, (hit && avs_read_i) ? next_rdata : 8'h00};
            // Response code stands with the read data until the next access
            avs_response_o <= hit ? 2'h0 : 2'h2;
        end
    end
end

// ----------------------------------------------------------------
// Register writes
// ----------------------------------------------------------------
always @(posedge clk_i)
begin
    if (!rst_n_i)
    begin
        sync_word_high <= `RPC_RST_SYNC_HIGH;
        sync_word_low <= `RPC_RST_SYNC_LOW;
        packet_length_limit <= `RPC_RST_PKT_LEN;
        packet_control_first <= `RPC_RST_PKT_CTRL1;
        packet_control_zero <= `RPC_RST_PKT_CTRL0;
        device_address <= `RPC_RST_DEV_ADDR;
        debug_pin_two_config <= `RPC_RST_PIN_CFG;
        debug_pin_one_config <= `RPC_RST_PIN_CFG;
        debug_pin_zero_config <= `RPC_RST_PIN_CFG;
    end
    else if (wr_en)
    begin
        case (index)
            `RPC_IDX_SYNC_HIGH: sync_word_high <= wdata;
            `RPC_IDX_SYNC_LOW: sync_word_low <= wdata;
            `RPC_IDX_PKT_LEN: packet_length_limit <= wdata;
            `RPC_IDX_PKT_CTRL1: packet_control_first <= wdata & `RPC_MASK_PKT_CTRL1;
            `RPC_IDX_PKT_CTRL0: packet_control_zero <= wdata & `RPC_MASK_PKT_CTRL0;
            `RPC_IDX_DEV_ADDR: device_address <= wdata;
            `RPC_IDX_PIN_TWO: debug_pin_two_config <= wdata & `RPC_MASK_PIN_TWO;
            `RPC_IDX_PIN_ONE: debug_pin_one_config <= wdata & `RPC_MASK_PIN_ONE;
            `RPC_IDX_PIN_ZERO: debug_pin_zero_config <= wdata & `RPC_MASK_PIN_ZERO;
            default: ;
        endcase
    end
end

// ----------------------------------------------------------------
// Debug pin muxing
// ----------------------------------------------------------------
// Pin configs side by side, pin zero in the low byte
assign pin_cfg_all = {debug_pin_two_config, debug_pin_one_config, debug_pin_zero_config};

// One selector, inverter and output flop per debug pin
genvar g;
generate
    for (g = 0; g < PIN_COUNT; g = g + 1)
    begin : g_pin
        wire [7:0] cfg;
        wire [5:0] sel;
        wire picked;
        reg q;
        assign cfg = pin_cfg_all[8*g +: 8];
        assign sel = cfg[`RPC_SEL_HI:0];
        // selector picks signal
        // Selectors beyond the signal count read back but pick a constant low, which the invert bit still flips
        assign picked = (sel < SIG_COUNT) ? radio_signals_i[sel] : 1'b0;
        // Registered so the pins never glitch during selector change
        always @(posedge clk_i)
        begin
            if (!rst_n_i)
                q <= 1'b0;
            else
                q <= picked ^ cfg[`RPC_BIT_INVERT];
        end
    end
endgenerate

// Output ports taken straight from the per-pin flops
always @*
begin
    debug_pin_zero_o = g_pin[0].q;
    debug_pin_one_o = g_pin[1].q;
    debug_pin_two_o = g_pin[2].q;
end

assign debug_drive_strength_o = debug_pin_one_config[`RPC_BIT_DRIVE];

assign status_bytes_enable_o = packet_control_first[`RPC_BIT_APPEND];
// Sync word handed over high byte first
assign sync_word_o = {sync_word_high, sync_word_low};

// ----------------------------------------------------------------
// Preamble quality gating
// ----------------------------------------------------------------
rpc_pq_estimator #(
    .CNT_W(PQ_W)
) u_pq (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .bit_valid_i(rx_bit_valid_i),
    .bit_i(rx_bit_i),
    .restart_i(rx_search_start_i),
    .threshold_i(packet_control_first[`RPC_PQT_HI:`RPC_PQT_LO]),
    .count_o(pq_count),
    .reached_o(pq_reached)
);

// ----------------------------------------------------------------
// Address filter and length decisions
// ----------------------------------------------------------------
// Compares against the byte now offered by the demodulator
assign addr_match = (rx_byte_i == device_address);
assign bcast_zero = (rx_byte_i == `RPC_BCAST_ZERO);
assign bcast_all = (rx_byte_i == `RPC_BCAST_ALL);

// Broadcast matches only count in the modes that allow them
always @*
begin
    next_address_ok = 1'b0;
    case (packet_control_first[`RPC_ADR_HI:0])
        `RPC_ADR_NONE:
            next_address_ok = 1'b1;
        `RPC_ADR_NOBC:
            next_address_ok = addr_match;
        `RPC_ADR_BC0:
            next_address_ok = addr_match || bcast_zero;
        `RPC_ADR_BC0FF:
            next_address_ok = addr_match || bcast_zero || bcast_all;
        default:
            next_address_ok = 1'b0;
    endcase
end

// limit caps variable length
// Oversized length bytes are clamped, not dropped, so the
// receiver never overruns a buffer sized to the limit
always @*
begin
    next_packet_length = rx_byte_i;
    if (rx_byte_i > packet_length_limit)
        next_packet_length = packet_length_limit;
end

// ----------------------------------------------------------------
// Length and address handling after sync
// ----------------------------------------------------------------
// Byte 0 is length in variable mode; the next byte is the address
always @(posedge clk_i)
begin
    if (!rst_n_i || rx_search_start_i)
    begin
        sync_detected_o <= 1'b0;
        in_packet <= 1'b0;
        byte_index <= 2'h0;
        packet_length_o <= 8'h00;
        length_valid_o <= 1'b0;
        address_ok_o <= 1'b0;
        address_valid_o <= 1'b0;
    end
    else
    begin
        sync_detected_o <= 1'b0;
        if (!in_packet && sync_match_i && pq_reached)
        begin
            sync_detected_o <= 1'b1;
            in_packet <= 1'b1;
            byte_index <= 2'h0;
            length_valid_o <= 1'b0;
            address_valid_o <= 1'b0;
            if (packet_control_zero[`RPC_LEN_HI:0] == `RPC_LEN_FIXED)
            begin
                packet_length_o <= packet_length_limit;
                length_valid_o <= 1'b1;
                byte_index <= 2'h1;
            end
        end
        else if (in_packet && rx_byte_valid_i && byte_index != 2'h2)
        begin
            byte_index <= byte_index + 2'h1;
            if (byte_index == 2'h0)
            begin
                packet_length_o <= next_packet_length;
                length_valid_o <= 1'b1;
            end
            else
            begin
                address_valid_o <= 1'b1;
                address_ok_o <= next_address_ok;
            end
        end
    end
end

endmodule // rpc_config_regs

/* rpc_config_regs_monitor.sv */
// Concurrent checks on the radio packet config register ports
`timescale 1ns/10ps
module rpc_config_regs_monitor (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Register bus
    input wire [17:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    input wire [31:0] avs_readdata_o,
    input wire avs_waitrequest_o,
    input wire [1:0] avs_response_o,
    // Packet side
    input wire sync_match_i,
    input wire sync_detected_o,
    input wire debug_drive_strength_o,
    input wire status_bytes_enable_o,
    input wire [15:0] sync_word_o
);
    // ------------------------------------------------------------
    // Helpers and properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Completed accesses; only lane zero carries register data
    wire [15:0] idx = avs_address_i[17:2];
    wire wr_done = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0]
        & (avs_address_i[1:0] == 2'b00);
    wire rd_done = avs_read_i & ~avs_waitrequest_o;
    wire wd_drive = avs_writedata_i[7];
    wire wd_app = avs_writedata_i[2];
    wire [7:0] wd = avs_writedata_i[7:0];

    first_wait_a: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
        else $error("no wait state on a new request");
    wait_one_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("wait state longer than one cycle");
    upper_zero_a: assert property (rd_done |-> avs_readdata_o[31:8] == 24'h0)
        else $error("upper read data not zero");
    unmapped_read_a: assert property (rd_done && idx == 16'hdf06
        |-> avs_response_o == 2'h2 && avs_readdata_o[7:0] == 8'h00) else $error("unmapped read");
    drive_bit_a: assert property (wr_done && idx == 16'hdf30
        |=> debug_drive_strength_o == $past(wd_drive)) else $error("drive strength");
    append_bit_a: assert property (wr_done && idx == 16'hdf03
        |=> status_bytes_enable_o == $past(wd_app)) else $error("status_bytes_enable enable");
    sync_high_a: assert property (wr_done && idx == 16'hdf00
        |=> sync_word_o[15:8] == $past(wd)) else $error("sync word high byte");
    sync_pulse_a: assert property (sync_detected_o |=> !sync_detected_o)
        else $error("sync detect longer than one cycle");
    sync_cause_a: assert property (sync_detected_o |-> $past(sync_match_i))
        else $error("sync detect without match");
endmodule // rpc_config_regs_monitor

bind rpc_config_regs rpc_config_regs_monitor mon (.*);

/* rpc_config_regs_tb.sv */
// Self-checking bench for the radio packet config registers
`timescale 1ns/10ps
module rpc_config_regs_tb;
    // ------------------------------------------------------------
    // Signals, tables and counters
    // ------------------------------------------------------------
    reg clk_i = 1'b0;
    reg rst_n_i = 1'b0;
    reg [17:0] avs_address_i = 18'h0;
    reg avs_read_i = 1'b0;
    reg avs_write_i = 1'b0;
    reg [31:0] avs_writedata_i = 32'h0;
    reg [3:0] avs_byteenable_i = 4'h0;
    reg [63:0] radio_signals_i = 64'h21;
    reg rx_bit_valid_i = 1'b0;
    reg rx_bit_i = 1'b0;
    reg rx_search_start_i = 1'b0;
    reg sync_match_i = 1'b0;
    reg rx_byte_valid_i = 1'b0;
    reg [7:0] rx_byte_i = 8'h0;
    wire [31:0] avs_readdata_o;
    wire avs_waitrequest_o;
    wire [1:0] avs_response_o;
    wire debug_pin_two_o, debug_pin_one_o, debug_pin_zero_o, debug_drive_strength_o;
    wire sync_detected_o, length_valid_o, address_ok_o, address_valid_o, status_bytes_enable_o;
    wire [7:0] packet_length_o;
    wire [15:0] sync_word_o;
    wire [2:0] pins = {debug_pin_two_o, debug_pin_one_o, debug_pin_zero_o};
    logic [15:0] ix [9] = '{16'hdf00, 16'hdf01, 16'hdf02, 16'hdf03, 16'hdf04, 16'hdf05,
        16'hdf2f, 16'hdf30, 16'hdf31};
    logic [7:0] rv [9] = '{8'hd3, 8'h91, 8'hff, 8'h04, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] mk [9] = '{8'hff, 8'hff, 8'hff, 8'he7, 8'h03, 8'hff, 8'h7f, 8'hff, 8'h7f};
    logic [7:0] dv [5] = '{8'h05, 8'h45, 8'h04, 8'h44, 8'h3f};
    logic [7:0] ad [3] = '{8'hff, 8'h00, 8'h12};
    logic [7:0] vl [2] = '{8'h30, 8'h10};
    int err_count = 0, checked = 0, cyc = 0, syncs = 0;
    reg [31:0] q;
    reg [1:0] r;
    logic ok;

    rpc_config_regs uut (.*);

    // Clock and a ceiling that cuts a hang short
    initial
    begin
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (sync_detected_o === 1'b1)
            syncs <= syncs + 1;
        if (cyc == 20000)
        begin
            err_count++;
            complete_run();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task check(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // Request held until the rising edge that samples waitrequest low
    task bus(input logic rd, input logic [15:0] idx, input logic [7:0] d, input logic [3:0] be);
        @(posedge clk_i);
        avs_read_i <= rd;
        avs_write_i <= ~rd;
        avs_address_i <= {idx, 2'b00};
        avs_writedata_i <= {24'h0, d};
        avs_byteenable_i <= be;
        @(posedge clk_i);
        while (avs_waitrequest_o !== 1'b0)
            @(posedge clk_i);
        q = avs_readdata_o;
        r = avs_response_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask
    task rdc(input logic [15:0] idx, input logic [7:0] e, input logic [1:0] er);
        bus(1'b1, idx, 8'h00, 4'h1);
        check(q, {24'h0, e});
        check({30'h0, r}, {30'h0, er});
    endtask
    task bits(input logic [7:0] pat, input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk_i);
            rx_bit_valid_i <= 1'b1;
            rx_bit_i <= pat[i];
        end
        @(posedge clk_i);
        rx_bit_valid_i <= 1'b0;
    endtask
    // One-cycle strobe: 0 restart, 1 correlator match, 2 received byte
    task pulse(input int k, input logic [7:0] b);
        @(posedge clk_i);
        rx_search_start_i <= (k == 0);
        sync_match_i <= (k == 1);
        rx_byte_valid_i <= (k == 2);
        rx_byte_i <= b;
        @(posedge clk_i);
        rx_search_start_i <= 1'b0;
        sync_match_i <= 1'b0;
        rx_byte_valid_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task complete_run;
        $display("Comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        @(negedge clk_i);
        check({29'h0, pins}, 32'h7);
        check({31'h0, status_bytes_enable_o}, 32'h1);
        check({16'h0, sync_word_o}, 32'hd391);
        for (int i = 0; i < 9; i++)
            rdc(ix[i], rv[i], 2'h0);
        for (int i = 0; i < 9; i++)
        begin
            bus(1'b0, ix[i], 8'hff, 4'h1);
            rdc(ix[i], mk[i], 2'h0);
        end
        check({31'h0, debug_drive_strength_o}, 32'h1);
        check({16'h0, sync_word_o}, 32'hffff);
        bus(1'b0, 16'hdf00, 8'h00, 4'h0);
        rdc(16'hdf00, 8'hff, 2'h0);
        rdc(16'hdf06, 8'h00, 2'h2);
        // Each pin follows its selected signal, flipped by the invert bit
        for (int p = 0; p < 3; p++)
            for (int v = 0; v < 5; v++)
            begin
                bus(1'b0, 16'hdf2f + p[15:0], dv[v], 4'h1);
                @(posedge clk_i);
                @(negedge clk_i);
                check({31'h0, pins[2-p]}, {31'h0, radio_signals_i[dv[v][5:0]] ^ dv[v][6]});
            end
        check({31'h0, debug_drive_strength_o}, 32'h0);
        // Quality threshold of one needs a count of four
        bus(1'b0, 16'hdf03, 8'h20, 4'h1);
        pulse(0, 8'h00);
        bits(8'h15, 5);
        rdc(16'hdf3c, 8'h04, 2'h0);
        bits(8'h01, 1);
        rdc(16'hdf3c, 8'h00, 2'h0);
        pulse(1, 8'h00);
        check(syncs, 32'h0);
        bits(8'h0a, 4);
        pulse(1, 8'h00);
        check(syncs, 32'h1);
        // Fixed length packets through every address filter mode
        bus(1'b0, 16'hdf05, 8'h12, 4'h1);
        bus(1'b0, 16'hdf02, 8'h20, 4'h1);
        bus(1'b0, 16'hdf04, 8'h00, 4'h1);
        for (int m = 0; m < 4; m++)
        begin
            bus(1'b0, 16'hdf03, m[7:0], 4'h1);
            for (int a = 0; a < 3; a++)
            begin
                pulse(0, 8'h00);
                pulse(1, 8'h00);
                check({24'h0, packet_length_o}, 32'h20);
                pulse(2, ad[a]);
                ok = m == 0 || ad[a] == 8'h12 || (m > 1 && ad[a] == 8'h00) ||
                    (m == 3 && ad[a] == 8'hff);
                check({length_valid_o, address_valid_o, address_ok_o}, {2'b11, ok});
            end
        end
        // Variable length: first byte, held to the limit
        bus(1'b0, 16'hdf04, 8'h01, 4'h1);
        check({31'h0, status_bytes_enable_o}, 32'h0);
        for (int a = 0; a < 2; a++)
        begin
            pulse(0, 8'h00);
            pulse(1, 8'h00);
            pulse(2, vl[a]);
            check({length_valid_o, packet_length_o}, {1'b1, vl[a] > 8'h20 ? 8'h20 : vl[a]});
        end
        complete_run();
    end
endmodule // rpc_config_regs_tb
